// ### rtl/sss_pkg.sv
// Package of the serial signal switch: selector codes, reset defaults,
// APB offsets and field positions of the controller's own registers.
// Assumes a single pclk domain shared by both ends.
// Overview of operation
// - Decoder select 00 zero, 01 analog receiver
// - Decoder select 10 takes subcarrier Manchester input
// - Decoder select 11 takes plain Manchester input
// - Modulator select 00 off, 01 steady carrier
// - Modulator select 10 uses internal encoder envelope
// - Modulator select 11 takes Miller input pin
// - Output select 000 low, 001 high; 110/111 reserved
// - Output 010 envelope, 011 unencoded transmit stream
// - Output 100 receiver signal, 101 demodulator result
// - Output select applies only without test override
// - Analog half: modulator 3, output 4
// - Digital half: output 2, decoder 2
// - Split antenna only at 106 kBd
// - Drive the two RF paths one at a time; the switch drives both antenna pins from the same mod_sig
// - Link rates 106, 212, 424 kBd supported
package sss_pkg;
  localparam logic [1:0] SSS_DEC_ZERO     = 2'h0;
  localparam logic [1:0] SSS_DEC_ANALOG   = 2'h1;
  localparam logic [1:0] SSS_DEC_SUBCAR   = 2'h2;
  localparam logic [1:0] SSS_DEC_MANCH    = 2'h3;
  localparam logic [1:0] SSS_MOD_OFF      = 2'h0;
  localparam logic [1:0] SSS_MOD_ON       = 2'h1;
  localparam logic [1:0] SSS_MOD_ENC      = 2'h2;
  localparam logic [1:0] SSS_MOD_PIN      = 2'h3;
  localparam logic [2:0] SSS_OUT_LOW      = 3'h0;
  localparam logic [2:0] SSS_OUT_HIGH     = 3'h1;
  localparam logic [2:0] SSS_OUT_ENV      = 3'h2;
  localparam logic [2:0] SSS_OUT_RAW      = 3'h3;
  localparam logic [2:0] SSS_OUT_RX       = 3'h4;
  localparam logic [2:0] SSS_OUT_DEMOD    = 3'h5;
  localparam logic [1:0] SSS_DEC_RST      = SSS_DEC_ANALOG;
  localparam logic [1:0] SSS_MOD_RST      = SSS_MOD_ENC;
  localparam logic [2:0] SSS_OUT_RST      = SSS_OUT_LOW;
  localparam logic [1:0] SSS_RATE_106     = 2'h0;
  localparam logic [1:0] SSS_RATE_212     = 2'h1;
  localparam logic [1:0] SSS_RATE_424     = 2'h2;
  localparam logic [1:0] SSS_RATE_RST     = SSS_RATE_106;
  // Controller register offsets (byte addresses)
  localparam logic [11:0] SSS_OFF_CTRL    = 12'h000;
  localparam logic [11:0] SSS_OFF_STAT    = 12'h004;
  // Control register field positions
  localparam int SSS_F_DEC = 0;
  localparam int SSS_F_MOD = 2;
  localparam int SSS_F_OUT = 4;
  localparam int SSS_F_OVR = 7;
  localparam int SSS_F_RATE = 8;
  localparam int SSS_F_PATH = 10;
  // Status field positions
  localparam int SSS_F_SIN = 0;
  localparam int SSS_F_SOUT = 1;
  localparam int SSS_F_REJ = 2;
endpackage : sss_pkg

// ### rtl/sss_if.sv
// Interface joining the switch (device) and its controller.
// Assumes both ends run on the same pclk; no clocking block.
`timescale 1ns/100ps
`default_nettype none
interface sss_if;
  logic [1:0] decoder_input_sel;
  logic [1:0] modulator_input_sel;
  logic [2:0] serial_out_sel;
  logic       test_path_override;
  logic [1:0] link_rate;
  logic       serial_out_pin;
  logic       serial_in_pin;
  modport device (input decoder_input_sel, modulator_input_sel, serial_out_sel,
                  test_path_override, link_rate, serial_in_pin,
                  output serial_out_pin);
  modport ctrl (output decoder_input_sel, modulator_input_sel, serial_out_sel,
                test_path_override, link_rate,
                input serial_out_pin, serial_in_pin);
endinterface : sss_if
`default_nettype wire

// ### rtl/sss_switch.sv
// Serial signal switch: registered selectors, pin sync, routing muxes.
// Assumes the selector inputs come from pclk logic; serial_in_pin is a pin.
`timescale 1ns/100ps
`default_nettype none
module sss_switch
  import sss_pkg::*;
(
  input  wire logic pclk,            // Core clock
  input  wire logic presetn,         // Async reset, active low
  sss_if.device     bus,             // Selector and pin side
  input  wire logic analog_rx,       // Analog receiver output
  input  wire logic encoder_env,     // Encoder envelope
  input  wire logic tx_raw,          // Unencoded transmit stream
  input  wire logic rx_regen,        // Regenerated card modulation
  input  wire logic demod_manch,     // Subcarrier demodulator result
  input  wire logic test_out,        // Test logic signal for the pin
  output logic      decoder_in,      // To Manchester decoder
  output logic      decoder_subcar,  // Decoder expects subcarrier
  output logic      antenna_drive_a, // Transmitter pin A
  output logic      antenna_drive_b, // Transmitter pin B
  output logic [1:0] rate            // Active link rate
);
  logic [1:0] dec_sel, next_dec_sel;
  logic [1:0] mod_sel, next_mod_sel;
  logic [2:0] out_sel, next_out_sel;
  logic       ovr, next_ovr;
  logic [1:0] next_rate;
  logic       sin_meta, sin_sync;
  logic       next_out_pin;
  logic       mod_sig;

  // Selector registers take the controller's values
  always_comb begin
    next_dec_sel = bus.decoder_input_sel;
    next_mod_sel = bus.modulator_input_sel;
    next_out_sel = bus.serial_out_sel;
    next_ovr     = bus.test_path_override;
    next_rate    = bus.link_rate;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_sel  <= SSS_DEC_RST;
      mod_sel  <= SSS_MOD_RST;
      out_sel  <= SSS_OUT_RST;
      ovr      <= 1'b0;
      rate     <= SSS_RATE_RST;
      sin_meta <= 1'b0;
      sin_sync <= 1'b0;
      bus.serial_out_pin <= 1'b0;
    end else begin
      dec_sel  <= next_dec_sel;
      mod_sel  <= next_mod_sel;
      out_sel  <= next_out_sel;
      ovr      <= next_ovr;
      rate     <= next_rate;
      sin_meta <= bus.serial_in_pin;  // Pin is asynchronous
      sin_sync <= sin_meta;
      bus.serial_out_pin <= next_out_pin;
    end
  end

  // Decoder source mux
  always_comb begin
    decoder_subcar = 1'b0;
    case (dec_sel)
      SSS_DEC_ZERO:   decoder_in = 1'b0;
      SSS_DEC_ANALOG: decoder_in = analog_rx;
      SSS_DEC_SUBCAR: begin
        decoder_in     = sin_sync;
        decoder_subcar = 1'b1;
      end
      SSS_DEC_MANCH:  decoder_in = sin_sync;
      default:        decoder_in = 1'b0;
    endcase
  end

  // Modulator source mux, same signal on both drivers
  always_comb begin
    case (mod_sel)
      SSS_MOD_OFF: mod_sig = 1'b0;
      SSS_MOD_ON:  mod_sig = 1'b1;
      SSS_MOD_ENC: mod_sig = encoder_env;
      SSS_MOD_PIN: mod_sig = sin_sync;
      default:     mod_sig = 1'b0;
    endcase
    antenna_drive_a = mod_sig;
    antenna_drive_b = mod_sig;
  end

  // Output mux; reserved codes read low rather than float
  always_comb begin
    if (ovr) begin
      next_out_pin = test_out;
    end else begin
      case (out_sel)
        SSS_OUT_LOW:   next_out_pin = 1'b0;
        SSS_OUT_HIGH:  next_out_pin = 1'b1;
        SSS_OUT_ENV:   next_out_pin = encoder_env;
        SSS_OUT_RAW:   next_out_pin = tx_raw;
        SSS_OUT_RX:    next_out_pin = rx_regen;
        SSS_OUT_DEMOD: next_out_pin = demod_manch;
        default:       next_out_pin = 1'b0;
      endcase
    end
  end
endmodule : sss_switch
`default_nettype wire

// ### rtl/sss_ctrl.sv
// Controller end: APB slave registers that steer the switch selectors.
// Assumes an APB master on pclk; only 106 kBd allowed with split antenna.
`timescale 1ns/100ps
`default_nettype none
module sss_ctrl
  import sss_pkg::*;
(
  input  wire logic        pclk,     // Core clock
  input  wire logic        presetn,  // Async reset, active low
  input  wire logic        psel,     // APB select
  input  wire logic        penable,  // APB enable
  input  wire logic        pwrite,   // APB direction
  input  wire logic [11:0] paddr,    // APB byte address
  input  wire logic [31:0] pwdata,   // APB write data
  output logic      [31:0] prdata,   // APB read data
  output logic             pready,   // APB ready
  output logic             pslverr,  // APB error
  sss_if.ctrl              bus       // Selector side
);
  logic [10:0] ctrl, next_ctrl;
  logic        rej, next_rej;
  logic [31:0] next_prdata;
  logic        sin_meta, sin_sync;
  logic        wr, rd, hit_c, hit_s;
  logic        split, active_rf;

  assign pready  = 1'b1;
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & ~penable & ~pwrite;  // Read seen in its setup cycle
  assign hit_c   = (paddr == SSS_OFF_CTRL);
  assign hit_s   = (paddr == SSS_OFF_STAT);
  assign pslverr = psel & penable & ~(hit_c | hit_s);
  // Split-antenna configs from the pending write
  assign split   = (pwdata[SSS_F_MOD+:2] == SSS_MOD_PIN & pwdata[SSS_F_OUT+:3] == SSS_OUT_RX)
                 | (pwdata[SSS_F_DEC+:2] == SSS_DEC_SUBCAR
                    & pwdata[SSS_F_OUT+:3] == SSS_OUT_ENV);
  assign active_rf = pwdata[SSS_F_PATH];

  // Write path; illegal combos refused and flagged
  always_comb begin
    next_ctrl = ctrl;
    next_rej  = rej;
    if (wr && hit_c) begin
      if ((split && pwdata[SSS_F_RATE+:2] != SSS_RATE_106)
          || pwdata[SSS_F_OUT+:3] > SSS_OUT_DEMOD
          || (active_rf && pwdata[SSS_F_MOD+:2] != SSS_MOD_PIN
              && pwdata[SSS_F_MOD+:2] != SSS_MOD_OFF)) begin
        next_rej = 1'b1;
      end else begin
        next_ctrl = pwdata[10:0];
        next_rej  = 1'b0;
      end
    end
  end

  // Read mux: data registered at the setup edge, so it stands through access
  // with zero wait states; status is therefore one cycle old when taken
  always_comb begin
    next_prdata = prdata;
    if (rd) begin
      next_prdata = 32'h0000_0000;
      if (hit_c) begin
        next_prdata[10:0] = ctrl;
      end else if (hit_s) begin
        next_prdata[SSS_F_SIN]  = sin_sync;
        next_prdata[SSS_F_SOUT] = bus.serial_out_pin;
        next_prdata[SSS_F_REJ]  = rej;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= {1'b0, SSS_RATE_RST, 1'b0, SSS_OUT_RST, SSS_MOD_RST, SSS_DEC_RST};
      rej      <= 1'b0;
      prdata   <= 32'h0000_0000;
      sin_meta <= 1'b0;
      sin_sync <= 1'b0;
    end else begin
      ctrl     <= next_ctrl;
      rej      <= next_rej;
      prdata   <= next_prdata;
      sin_meta <= bus.serial_in_pin;
      sin_sync <= sin_meta;
    end
  end

  // Selectors follow the control register as levels
  assign bus.decoder_input_sel   = ctrl[SSS_F_DEC+:2];
  assign bus.modulator_input_sel = ctrl[SSS_F_MOD+:2];
  assign bus.serial_out_sel      = ctrl[SSS_F_OUT+:3];
  assign bus.test_path_override  = ctrl[SSS_F_OVR];
  assign bus.link_rate           = ctrl[SSS_F_RATE+:2];
endmodule : sss_ctrl
`default_nettype wire

// ### tb/sss_properties.sv
// Checker for the switch link: selector legality and pin routing timing.
// Assumes sss_if signals sampled on pclk under async low presetn.
`timescale 1ns/100ps
`default_nettype none
module sss_properties
  import sss_pkg::*;
(
  input wire logic       pclk,                // Core clock
  input wire logic       presetn,             // Reset, active low
  input wire logic [1:0] decoder_input_sel,   // Decoder route
  input wire logic [1:0] modulator_input_sel, // Modulator route
  input wire logic [2:0] serial_out_sel,      // Output route
  input wire logic       test_path_override,  // Test owns pin
  input wire logic [1:0] link_rate,           // Link rate code
  input wire logic       serial_out_pin       // Serial output
);
  logic rst_seen;  // Reset already seen at the previous edge

  // Flops are unset at the very first edge in reset; reset checks wait one edge
  always_ff @(posedge pclk) begin
    rst_seen <= !presetn;
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Constant routes: selector held two edges, then the pin follows
  chk_out_low: assert property (
    (serial_out_sel == SSS_OUT_LOW && !test_path_override)[*2] |=> !serial_out_pin)
    else $error("pin not low");
  chk_out_high: assert property (
    (serial_out_sel == SSS_OUT_HIGH && !test_path_override)[*2] |=> serial_out_pin)
    else $error("pin not high");
  // A new route must not show early: one stale cycle, then the new level
  chk_out_lag: assert property (
    $past(serial_out_sel) == SSS_OUT_LOW && !$past(test_path_override)
    && serial_out_sel == SSS_OUT_HIGH && !test_path_override
    |=> (!test_path_override && !serial_out_pin) ##1 serial_out_pin)
    else $error("route lag");
  chk_out_reserved: assert property (serial_out_sel < 3'h6) else $error("reserved code");
  // Split antenna settings only at the base rate
  chk_analog_rate: assert property (
    modulator_input_sel == SSS_MOD_PIN && serial_out_sel == SSS_OUT_RX
    |-> link_rate == SSS_RATE_106) else $error("rate");
  chk_digital_rate: assert property (
    decoder_input_sel == SSS_DEC_SUBCAR && serial_out_sel == SSS_OUT_ENV
    |-> link_rate == SSS_RATE_106) else $error("rate");
  // Reset checks stay live while reset is low, from its second edge on
  chk_sel_defaults: assert property (disable iff (1'b0)
    rst_seen && !presetn |-> decoder_input_sel == SSS_DEC_RST
    && modulator_input_sel == SSS_MOD_RST && serial_out_sel == SSS_OUT_RST)
    else $error("bad defaults");
  chk_pin_reset: assert property (disable iff (1'b0)
    rst_seen && !presetn |-> !serial_out_pin)
    else $error("pin in reset");
endmodule : sss_properties
`default_nettype wire

// ### tb/serial_signal_switch_tb_top.sv
// Testbench top: APB controller steering the switch through sss_if.
// Assumes 25 MHz pclk and prdata standing at the access edge.
`timescale 1ns/100ps
`default_nettype none
module serial_signal_switch_tb_top;
  import sss_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, se, dec_in, subcar, ant_a, ant_b;
  logic        analog_rx = 0, encoder_env = 0, tx_raw = 0, rx_regen = 0, demod_manch = 0;
  logic        test_out = 0;
  logic [1:0]  rate;
  logic [31:0] rc[8] = '{32'h60, 32'h70, 32'h24C, 32'h04C, 32'h122, 32'h404, 32'h100, 32'h200};
  logic        rj[8] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  int          error_cnt = 0, samples_checked = 0;
  sss_if u_sss_if ();
  initial u_sss_if.serial_in_pin = 1'b0;
  sss_ctrl u_sss_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .bus(u_sss_if.ctrl));
  sss_switch u_sss_switch (.pclk, .presetn, .bus(u_sss_if.device), .analog_rx, .encoder_env,
    .tx_raw, .rx_regen, .demod_manch, .test_out, .decoder_in(dec_in), .decoder_subcar(subcar),
    .antenna_drive_a(ant_a), .antenna_drive_b(ant_b), .rate);
  sss_properties u_sss_properties (.pclk, .presetn,
    .decoder_input_sel(u_sss_if.decoder_input_sel),
    .modulator_input_sel(u_sss_if.modulator_input_sel),
    .serial_out_sel(u_sss_if.serial_out_sel), .test_path_override(u_sss_if.test_path_override),
    .link_rate(u_sss_if.link_rate), .serial_out_pin(u_sss_if.serial_out_pin));
  always #20 pclk = ~pclk;
  // One APB transfer; read data and error are taken at the access edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    se = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // Expected {subcar, decoder, ant a, ant b, pin}; s = {sin,analog,env,raw,regen,demod,test}
  function automatic logic [4:0] expect_of(input logic [10:0] c, input logic [6:0] s);
    logic [5:0] o;
    logic [3:0] d;
    logic [3:0] m;
    o = {s[1], s[2], s[3], s[4], 1'b1, 1'b0};
    d = {s[6], s[6], s[5], 1'b0};
    m = {s[6], s[4], 1'b1, 1'b0};
    return {c[1:0] == SSS_DEC_SUBCAR, d[c[1:0]], m[c[3:2]], m[c[3:2]], c[7] ? s[0] : o[c[6:4]]};
  endfunction : expect_of
  // Set the side inputs, program the route, let the pin settle, compare
  task automatic step(input logic [10:0] c, input logic [6:0] s);
    @(posedge pclk);
    {u_sss_if.serial_in_pin, analog_rx, encoder_env, tx_raw, rx_regen, demod_manch, test_out} <= s;
    apb(1'b1, SSS_OFF_CTRL, {21'h0, c});
    repeat (3) @(posedge pclk);
    chk({27'h0, subcar, dec_in, ant_a, ant_b, u_sss_if.serial_out_pin}, {27'h0, expect_of(c, s)});
  endtask : step
  task automatic rst;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, SSS_OFF_CTRL, 32'h0);
    chk(rd, 32'h9);
  endtask : rst
  // Watchdog sized well above the roughly 760 cycles of traffic
  initial begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    results();
  end
  initial begin
    rst();
    for (int i = 0; i < 96; i++)
      step({4'h0, 3'(i / 16), 2'(i / 4), 2'(i)}, 7'(i*19+5));
    foreach (rc[k]) begin
      apb(1'b1, SSS_OFF_CTRL, rc[k]);
      apb(1'b0, SSS_OFF_STAT, 32'h0);
      chk({31'h0, rd[SSS_F_REJ]}, {31'h0, rj[k]});
    end
    chk({30'h0, rate}, {30'h0, SSS_RATE_424});
    apb(1'b0, 12'h008, 32'h0);
    chk({se, rd[30:0]}, 32'h80000000);
    step(11'h090, 7'h01);
    apb(1'b0, SSS_OFF_STAT, 32'h0);
    chk(rd, 32'h2);
    step(11'h090, 7'h7E);
    apb(1'b0, SSS_OFF_STAT, 32'h0);
    chk(rd, 32'h1);
    rst();
    results();
  end
endmodule : serial_signal_switch_tb_top
`default_nettype wire
